/* rtl/spc_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spc_cfg.svh"
// Summary of operation
// - bits 31:16 set awake time after a wake event before resuspend
// - software return to normal operation abandons the resuspend timeout
// - wake duration resets to 03e8h, ten milliseconds
// - zero wake duration means wake events never leave suspend
// - ffffh gives the longest interval, about 655 ms
// - one count per 10 us slow clock period
// - in 16-bit bus mode any duration write fixes 50 ms
// - bit 12 set disconnects port 3 pull-downs in suspend
// - bit 11 set disconnects port 2 pull-downs in suspend
// - low byte layout; bias and bit 7 reset to one
// - per-port overcurrent bit set powers its detector off in suspend
// - bit 4 set turns regulators off in suspend
// - bit 5 set keeps bias circuits powered in suspend
// - bit 10 set disables supply detector in suspend
module spc_top (
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    input  wire spc_pkg::spc_wr_s  wr_i,
    input  wire logic              slow_timing_clock_i,
    input  wire logic              wake_event_i,
    input  wire logic              normal_request_i,
    input  wire logic              suspend_request_i,
    output logic [31:0]            rdata_o,
    output spc_pkg::spc_ctl_s      ctl_o,
    output logic                   suspended_o,
    output logic                   awake_o
);
    import spc_pkg::*;

    // ************************************************************
    // register
    // ************************************************************
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;

    // reserved bits are not writable, so they keep their reset value
    always_comb begin
        next_ctrl = ctrl;
        if (wr_i.wr) begin
            next_ctrl = (wr_i.data & `SPC_RW_MASK) | (`SPC_REG_RESET & ~`SPC_RW_MASK);
            if (wr_i.bus16) begin
                next_ctrl[`SPC_WAKE_MSB:`SPC_WAKE_LSB] = `SPC_FIXED_WAKE_CNT;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ctrl <= `SPC_REG_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    logic [15:0] wake_len;
    assign wake_len = ctrl[`SPC_WAKE_MSB:`SPC_WAKE_LSB];

    // ************************************************************
    // slow clock and wake event sampling
    // ************************************************************
    logic slow_level;
    logic slow_tick;
    logic wake_level;
    logic wake_rise;

    spc_sync u_slow (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i (slow_timing_clock_i),
        .level_o (slow_level),
        .rise_o  (slow_tick)
    );

    spc_sync u_wake (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i (wake_event_i),
        .level_o (wake_level),
        .rise_o  (wake_rise)
    );

    // ************************************************************
    // suspend state machine
    // ************************************************************
    spc_state_e state;
    spc_state_e next_state;
    logic       t_load;
    logic       t_abort;
    logic       t_expired;
    logic       t_busy;

    // zero duration keeps the part suspended until a normal request
    always_comb begin
        next_state = state;
        t_load     = 1'b0;
        t_abort    = 1'b0;
        case (state)
            SPC_SUSPENDED: begin
                if (normal_request_i) begin
                    next_state = SPC_NORMAL;
                end else if (wake_rise && wake_len != 16'h0000) begin
                    next_state = SPC_AWAKE;
                    t_load     = 1'b1;
                end
            end
            SPC_AWAKE: begin
                if (normal_request_i) begin
                    next_state = SPC_NORMAL;
                    t_abort    = 1'b1;
                end else if (t_expired) begin
                    next_state = SPC_SUSPENDED;
                end
            end
            SPC_NORMAL: begin
                if (suspend_request_i) begin
                    next_state = SPC_SUSPENDED;
                end
            end
            default: begin
                next_state = SPC_SUSPENDED;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state <= SPC_NORMAL;
        end else begin
            state <= next_state;
        end
    end

    // one count per slow period; ffffh reaches ~655 ms nominal, ~468 ms at +40% clock
    spc_timer #(
        .WIDTH (16)
    ) u_timer (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .load_i    (t_load),
        .value_i   (wake_len),
        .tick_i    (slow_tick),
        .abort_i   (t_abort),
        .expired_o (t_expired),
        .busy_o    (t_busy)
    );

    // ************************************************************
    // outputs
    // ************************************************************
    spc_ctl_s next_ctl;

    always_comb begin
        next_ctl.clock_enable        = ctrl[`SPC_BIT_CLK_EN];
        next_ctl.overcurrent_off     = ctrl[`SPC_BIT_OC3:`SPC_BIT_OC1];
        next_ctl.regulator_off       = ctrl[`SPC_BIT_VREG];
        next_ctl.bias_keep           = ctrl[`SPC_BIT_BIAS];
        next_ctl.supply_detector_off = ctrl[`SPC_BIT_VDET];
        next_ctl.pulldown_off        = {ctrl[`SPC_BIT_PD3], ctrl[`SPC_BIT_PD2]};
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_o     <= `SPC_REG_RESET;
            ctl_o       <= spc_ctl_s'(9'h008); // only bias_keep set out of reset; every power-off bit clear
            suspended_o <= 1'b0;
            awake_o     <= 1'b0;
        end else begin
            rdata_o     <= next_ctrl;
            ctl_o       <= next_ctl;
            suspended_o <= (next_state == SPC_SUSPENDED);
            awake_o     <= (next_state == SPC_AWAKE);
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_wake_reset: assert property (@(posedge clock_i)
        $rose(rst_n_i) |-> wake_len == `SPC_WAKE_RESET)
        else $error("wake duration reset value wrong");
    a_zero_stays: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state == SPC_SUSPENDED && wake_len == 16'h0000 && !normal_request_i
        |=> state == SPC_SUSPENDED)
        else $error("left suspend with zero duration");
    a_wake_load: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        t_load |=> t_busy && state == SPC_AWAKE)
        else $error("wake event did not start timer");
    a_abort_normal: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state == SPC_AWAKE && normal_request_i |=> state == SPC_NORMAL && !t_busy)
        else $error("timeout not abandoned");
    a_expire_susp: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state == SPC_AWAKE && t_expired && !normal_request_i |=> ##1 suspended_o)
        else $error("no resuspend at expiry");
    a_bus16_fixed: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        wr_i.wr && wr_i.bus16 |=> wake_len == `SPC_FIXED_WAKE_CNT)
        else $error("16-bit write not fixed 50 ms");
    a_wide_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        wr_i.wr && !wr_i.bus16 |=> wake_len == $past(wr_i.data[31:16]))
        else $error("wake field not written");
    a_ctl_follow: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        wr_i.wr |=> ##1 ctl_o.pulldown_off == $past(wr_i.data[12:11], 2)
        && ctl_o.bias_keep == $past(wr_i.data[5], 2))
        else $error("control outputs do not follow register");
    a_tick_only: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        t_busy && !slow_tick && !t_abort && !t_load |=> !t_expired)
        else $error("timer moved without slow tick");
    a_reserved: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ctrl[15:13] == 3'h0 && ctrl[9:6] == 4'h2)
        else $error("reserved bits changed");

    // ************************************************************
    // output and state consistency checks
    // ************************************************************
    // readback always mirrors the live register
    a_rdata_mirror: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        rdata_o == ctrl)
        else $error("readback differs from register");

    // flags are registered copies of the state, never both set
    a_susp_flag: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        suspended_o == (state == SPC_SUSPENDED))
        else $error("suspend flag does not match state");
    // awake flag tracks the awake state
    a_awake_flag: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        awake_o == (state == SPC_AWAKE))
        else $error("awake flag does not match state");
    // the two flags are exclusive
    a_flags_excl: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !(suspended_o && awake_o))
        else $error("suspended and awake together");

    // each control output lags its register bit by one edge
    a_pd3_follow: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        1'b1 |=> ctl_o.pulldown_off[1] == $past(ctrl[`SPC_BIT_PD3]))
        else $error("port 3 pull-down control wrong");
    // port 2 pull-down control
    a_pd2_follow: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        1'b1 |=> ctl_o.pulldown_off[0] == $past(ctrl[`SPC_BIT_PD2]))
        else $error("port 2 pull-down control wrong");
    // overcurrent detector power, ports 3 down to 1
    a_oc_follow: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        1'b1 |=> ctl_o.overcurrent_off == $past(ctrl[`SPC_BIT_OC3:`SPC_BIT_OC1]))
        else $error("overcurrent power control wrong");
    // regulator control
    a_vreg_follow: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        1'b1 |=> ctl_o.regulator_off == $past(ctrl[`SPC_BIT_VREG]))
        else $error("regulator control wrong");
    // supply detector control
    a_vdet_follow: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        1'b1 |=> ctl_o.supply_detector_off == $past(ctrl[`SPC_BIT_VDET]))
        else $error("supply detector control wrong");
    // clock enable bit
    a_clken_follow: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        1'b1 |=> ctl_o.clock_enable == $past(ctrl[`SPC_BIT_CLK_EN]))
        else $error("clock enable control wrong");
    // bias stays powered straight out of reset
    a_bias_reset: assert property (@(posedge clock_i)
        $rose(rst_n_i) |-> ctl_o.bias_keep)
        else $error("bias control reset value wrong");

    // timer never started with a zero duration
    a_no_zero_load: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        t_load |-> wake_len != 16'h0000)
        else $error("timer loaded with zero");
    // back in normal operation the timer stays idle
    a_normal_idle: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state == SPC_NORMAL |-> !t_busy)
        else $error("timer running in normal operation");
    // expiry only ever seen while awake
    a_expire_awake: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        t_expired |-> state == SPC_AWAKE)
        else $error("expiry outside awake state");

    // duration field only moves on a write
    a_wake_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !wr_i.wr |=> $stable(wake_len))
        else $error("wake duration changed without write");
    // narrow-bus write still lands the low half normally
    a_bus16_low: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        wr_i.wr && wr_i.bus16 |=>
        ctrl[15:0] == (($past(wr_i.data[15:0]) & 16'h1c3f) | 16'h0080))
        else $error("16-bit write low half wrong");

    c_zero_block: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        state == SPC_SUSPENDED && wake_rise && wake_len == 16'h0000);
    c_wake: cover property (@(posedge clock_i) disable iff (!rst_n_i) t_load);
    c_expire: cover property (@(posedge clock_i) disable iff (!rst_n_i) t_expired);
    c_abort: cover property (@(posedge clock_i) disable iff (!rst_n_i) t_abort);
    c_bus16: cover property (@(posedge clock_i) disable iff (!rst_n_i) wr_i.wr && wr_i.bus16);
endmodule
`default_nettype wire

/* rtl/spc_cfg.svh */
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH
// field positions of the suspend power control word
`define SPC_WAKE_MSB        31
`define SPC_WAKE_LSB        16
`define SPC_BIT_CLK_EN      0
`define SPC_BIT_OC1         1
`define SPC_BIT_OC2         2
`define SPC_BIT_OC3         3
`define SPC_BIT_VREG        4
`define SPC_BIT_BIAS        5
`define SPC_BIT_VDET        10
`define SPC_BIT_PD2         11
`define SPC_BIT_PD3         12
// reset values
`define SPC_WAKE_RESET      16'h03e8
`define SPC_REG_RESET       32'h03e8_00a0
// writable bit mask: reserved bits read back as their reset value
`define SPC_RW_MASK         32'hffff_1c3f
// timing
`define SPC_SLOW_PERIOD_US  10
`define SPC_FIXED_WAKE_MS   50
`define SPC_FIXED_WAKE_CNT  16'(`SPC_FIXED_WAKE_MS * 1000 / `SPC_SLOW_PERIOD_US)
`endif

/* rtl/spc_pkg.sv */
package spc_pkg;
    // register write request
    typedef struct packed {
        logic        wr;
        logic        bus16;
        logic [31:0] data;
    } spc_wr_s;
    // suspend power controls towards the analog side
    typedef struct packed {
        logic       clock_enable;
        logic [2:0] overcurrent_off;
        logic       regulator_off;
        logic       bias_keep;
        logic       supply_detector_off;
        logic [1:0] pulldown_off;
    } spc_ctl_s;
    typedef enum logic [1:0] {
        SPC_SUSPENDED,
        SPC_AWAKE,
        SPC_NORMAL
    } spc_state_e;
endpackage

/* rtl/spc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser with a stage-one/two agreement filter
module spc_sync (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic async_i,
    output logic      level_o,
    output logic      rise_o
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic       next_level;
    logic       next_rise;

    // stage 0 is only read by stage 1
    always_comb begin
        next_stage = {stage[1:0], async_i};
        next_level = level_o;
        next_rise  = 1'b0;
        if (stage[1] == stage[2]) begin
            next_level = stage[2];
            next_rise  = stage[2] & ~level_o;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            stage   <= 3'h0;
            level_o <= 1'b0;
            rise_o  <= 1'b0;
        end else begin
            stage   <= next_stage;
            level_o <= next_level;
            rise_o  <= next_rise;
        end
    end
endmodule
`default_nettype wire

/* rtl/spc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// down counter paced by slow clock ticks
module spc_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] value_i,
    input  wire logic             tick_i,
    input  wire logic             abort_i,
    output logic                  expired_o,
    output logic                  busy_o
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic             next_busy;
    logic             next_expired;

    // abort beats load; expiry is a one-cycle pulse
    always_comb begin
        next_count   = count;
        next_busy    = busy_o;
        next_expired = 1'b0;
        if (abort_i) begin
            next_busy = 1'b0;
        end else if (load_i) begin
            next_count = value_i;
            next_busy  = 1'b1;
        end else if (busy_o && tick_i) begin
            if (count <= WIDTH'(1)) begin
                next_count   = '0;
                next_busy    = 1'b0;
                next_expired = 1'b1;
            end else begin
                next_count = count - WIDTH'(1);
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            count     <= '0;
            busy_o    <= 1'b0;
            expired_o <= 1'b0;
        end else begin
            count     <= next_count;
            busy_o    <= next_busy;
            expired_o <= next_expired;
        end
    end
endmodule
`default_nettype wire

/* verif/spc_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module spc_top_bench;
    import spc_pkg::*;
    // ***************************************
    // signals and instance
    // ***************************************
    logic              clock_i;
    logic              rst_n_i;
    spc_wr_s           wr_i;
    logic              slow_timing_clock_i;
    logic              wake_event_i;
    logic              normal_request_i;
    logic              suspend_request_i;
    logic [31:0]       rdata_o;
    spc_ctl_s          ctl_o;
    logic              suspended_o;
    logic              awake_o;
    int                n_errors;
    int                samples_checked;
    int                cycles;
    int                b;
    int                b_list [9] = '{0, 1, 2, 3, 4, 5, 10, 11, 12};
    spc_top i_dut (
        .clock_i             (clock_i),
        .rst_n_i             (rst_n_i),
        .wr_i                (wr_i),
        .slow_timing_clock_i (slow_timing_clock_i),
        .wake_event_i        (wake_event_i),
        .normal_request_i    (normal_request_i),
        .suspend_request_i   (suspend_request_i),
        .rdata_o             (rdata_o),
        .ctl_o               (ctl_o),
        .suspended_o         (suspended_o),
        .awake_o             (awake_o)
    );
    // ***************************************
    // clock, timeout and verdict
    // ***************************************
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    // ceiling well above the roughly 450 cycles the tests take
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            $display("BAD %0t timeout", $time);
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ***************************************
    // compare tasks and expectations
    // ***************************************
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_ctl(input spc_ctl_s got, input spc_ctl_s exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t controls %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    // reserved bits read as reset value: bit 7 one, the others zero
    function automatic logic [31:0] exp_word(input logic [31:0] d);
        exp_word = (d & 32'hffff_1c3f) | 32'h0000_0080;
    endfunction
    function automatic spc_ctl_s exp_ctl(input logic [31:0] d);
        exp_ctl = '{clock_enable: d[0], overcurrent_off: {d[3], d[2], d[1]},
                    regulator_off: d[4], bias_keep: d[5], supply_detector_off: d[10],
                    pulldown_off: {d[12], d[11]}};
    endfunction
    // ***************************************
    // access tasks
    // ***************************************
    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    // one write, then one extra edge so the controls have landed too
    task automatic write(input logic [31:0] d, input logic b16);
        step(1);
        wr_i = '{wr: 1'b1, bus16: b16, data: d};
        step(1);
        wr_i.wr = 1'b0;
        step(1);
    endtask
    task automatic write_chk(input logic [31:0] d);
        write(d, 1'b0);
        chk32(rdata_o, exp_word(d));
        chk_ctl(ctl_o, exp_ctl(d));
    endtask
    // one slow clock period, far longer than the synchroniser delay
    task automatic tick();
        slow_timing_clock_i = 1'b1;
        step(20);
        slow_timing_clock_i = 1'b0;
        step(20);
    endtask
    task automatic enter_suspend();
        int k;
        suspend_request_i = 1'b1;
        step(1);
        suspend_request_i = 1'b0;
        for (k = 0; k < 20 && suspended_o !== 1'b1; k++) step(1);
        chk1(suspended_o, 1'b1);
    endtask
    task automatic wake();
        wake_event_i = 1'b1;
        step(10);
        wake_event_i = 1'b0;
        step(1);
    endtask
    // ***************************************
    // main sequence
    // ***************************************
    initial begin
        cycles = 0;
        n_errors = 0;
        samples_checked = 0;
        rst_n_i = 1'b0;
        wr_i = '0;
        slow_timing_clock_i = 1'b0;
        wake_event_i = 1'b0;
        normal_request_i = 1'b0;
        suspend_request_i = 1'b0;
        step(20);
        rst_n_i = 1'b1;
        chk32(rdata_o, 32'h03e8_00a0);
        chk_ctl(ctl_o, exp_ctl(32'h0000_0020));
        chk1(suspended_o, 1'b0);
        $display("test reset done");
        // walk each control bit alone, then all ones and all zeros
        // reserved bit 7 is always written with its reset value of one
        foreach (b_list[i]) write_chk((32'h1 << b_list[i]) | 32'h80);
        write_chk(32'hffff_1cbf);
        write_chk(32'h0000_0080);
        $display("test fields done");
        write(32'h1234_08a1, 1'b1);
        chk32(rdata_o, {16'd5000, 16'h0000} | exp_word(32'h0000_08a1));
        $display("test bus16 done");
        // awake time of three slow ticks, then automatic return
        write_chk(32'h0003_0080);
        enter_suspend();
        wake();
        chk1(awake_o, 1'b1);
        tick();
        tick();
        chk1(awake_o, 1'b1);
        chk1(suspended_o, 1'b0);
        tick();
        chk1(suspended_o, 1'b1);
        chk1(awake_o, 1'b0);
        $display("test timeout done");
        // software restores normal operation mid-interval
        wake();
        chk1(awake_o, 1'b1);
        normal_request_i = 1'b1;
        step(1);
        normal_request_i = 1'b0;
        step(4);
        for (b = 0; b < 5; b++) tick();
        chk1(suspended_o, 1'b0);
        chk1(awake_o, 1'b0);
        $display("test abort done");
        // zero duration keeps the device suspended through a wake event
        write_chk(32'h0000_0080);
        enter_suspend();
        wake();
        step(20);
        chk1(awake_o, 1'b0);
        chk1(suspended_o, 1'b1);
        $display("test zero done");
        end_of_test();
    end
endmodule
`default_nettype wire
